// File: core/pld_defs.svh
// Constants of the fuse-programmed array logic model.
// Assumes inclusion by bare name; every file that names a constant includes it.
`ifndef PLD_DEFS_SVH
`define PLD_DEFS_SVH

// Array geometry
`define PLD_DED_INPUTS 12
`define PLD_MACROCELLS 10
`define PLD_ARRAY_INPUTS 22
`define PLD_COLS 44
`define PLD_SEL_W 4
// Product terms: sum terms per macrocell, then enables, set, reset
`define PLD_TERMS_MC0 8
`define PLD_TERMS_MC1 10
`define PLD_TERMS_MC2 12
`define PLD_TERMS_MC3 14
`define PLD_TERMS_MC4 16
`define PLD_TERMS_MC5 16
`define PLD_TERMS_MC6 14
`define PLD_TERMS_MC7 12
`define PLD_TERMS_MC8 10
`define PLD_TERMS_MC9 8
`define PLD_SUM_TERMS 120
`define PLD_TERM_OE_BASE 120
`define PLD_TERM_SET 130
`define PLD_TERM_RESET 131
`define PLD_TERMS_TOTAL 132
// Fuse address map of the verification read path
`define PLD_ADDR_W 13
`define PLD_ARRAY_FUSES 5808
`define PLD_POL_FUSE_BASE 13'h16B0
`define PLD_MODE_FUSE_BASE 13'h16BA
`define PLD_SEC_FUSE_ADDR 13'h16C4
`define PLD_FUSE_TOTAL 13'h16C5
// Fuse and register values
`define PLD_FUSE_OPEN 1'h1
`define PLD_POL_ACTIVE_LOW 1'h0
`define PLD_MODE_REGISTERED 1'h0
`define PLD_REG_CLEAR 1'h0
`define PLD_REG_SET 1'h1

`endif

// File: core/pld_pkg.sv
// Types shared by the array logic model.
// Assumes pld_defs.svh is on the include path.
`include "pld_defs.svh"

package pld_pkg;
  typedef logic [`PLD_ARRAY_INPUTS-1:0] array_in_t;
  typedef logic [`PLD_COLS-1:0] lit_vec_t;
  typedef logic [`PLD_MACROCELLS-1:0] mc_vec_t;
endpackage : pld_pkg

// File: core/sop_term.sv
// One programmable AND term of the array.
// Assumes a fuse bit of one means open, which drops that literal from the term.
module sop_term #(
  parameter int WIDTH = 44
) (
  input wire logic [WIDTH-1:0] lits,
  input wire logic [WIDTH-1:0] fuse_open,
  output logic term
);

  // Open fuses read as true so only connected literals gate the term
  assign term = &(lits | fuse_open);

endmodule : sop_term

// File: core/macrocell_slice.sv
// One output macrocell: OR of its terms, register, polarity and feedback select.
// Assumes terms, set and reset come from the same clock domain; pin_in is synchronised.
`include "pld_defs.svh"

module macrocell_slice #(
  parameter int N_TERMS = 8
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [N_TERMS-1:0] terms,
  input wire logic set_term,
  input wire logic reset_term,
  input wire logic preload_load,
  input wire logic preload_val,
  input wire logic feedback_mode_fuse,
  input wire logic output_polarity_fuse,
  input wire logic pin_in,
  output logic q_vis,
  output logic feedback,
  output logic pin_level
);

  logic q_ff;
  logic nxt_q;
  logic sum;

  // OR plane of this macrocell
  assign sum = |terms;

  // Next register value, reset term first
  always_comb begin
    if (reset_term) begin
      nxt_q = `PLD_REG_CLEAR;
    end else if (preload_load) begin
      nxt_q = preload_val;
    end else if (set_term) begin
      nxt_q = `PLD_REG_SET;
    end else begin
      nxt_q = sum;
    end
  end

  // Register, cleared at power-up
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= `PLD_REG_CLEAR;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Reset term masks the register at once, no edge needed
  assign q_vis = q_ff & ~reset_term;

  // Output select and sense
  always_comb begin
    if (feedback_mode_fuse == `PLD_MODE_REGISTERED) begin
      pin_level = q_vis ^ (output_polarity_fuse == `PLD_POL_ACTIVE_LOW);
      feedback = q_ff; // Straight from the register: no loop through the reset term
    end else begin
      pin_level = sum ^ (output_polarity_fuse == `PLD_POL_ACTIVE_LOW);
      feedback = pin_in;
    end
  end

  sequence s_set_edge;
    set_term && !reset_term && !preload_load;
  endsequence

  sequence s_reg_high;
    q_ff; // Visible value may already be masked by a fresh reset term
  endsequence

  property p_set_loads;
    @(posedge core_clk) disable iff (!rstn) s_set_edge |=> s_reg_high;
  endproperty

  a_set_loads_one: assert property (p_set_loads)
    else $error("set term did not load one");

  a_reset_clears_now: assert property (@(posedge core_clk) disable iff (!rstn)
    reset_term |-> !q_vis ##1 !q_ff)
    else $error("reset term did not clear register");

  a_reset_over_set: assert property (@(posedge core_clk) disable iff (!rstn)
    set_term && reset_term |=> !q_ff)
    else $error("set won over reset");

  a_preload_state: assert property (@(posedge core_clk) disable iff (!rstn)
    preload_load && !reset_term |=> q_ff == $past(preload_val))
    else $error("preload value not loaded");

  a_powerup_clear: assert property (@(posedge core_clk)
    rstn && !$past(rstn) |-> !q_ff)
    else $error("register not cleared at power-up");

  a_pin_feedback: assert property (@(posedge core_clk) disable iff (!rstn)
    feedback_mode_fuse |-> feedback == pin_in)
    else $error("combinational cell not fed back from pin");

  a_reg_polarity: assert property (@(posedge core_clk) disable iff (!rstn)
    !feedback_mode_fuse |-> pin_level == (q_vis ^ !output_polarity_fuse))
    else $error("registered pin level has wrong sense");

endmodule : macrocell_slice

// File: core/pld_output_macrocell_array.sv
// Top of the fuse-programmed array logic model: input sync, AND array,
// ten macrocells, registered pin drivers, test preload and fuse read path.
// Assumes fuse, preload and verify ports are static or on core_clk; pins are
// asynchronous and pass two flip-flops. The bench resolves each pin wire.
`include "pld_defs.svh"

module pld_output_macrocell_array #(
  parameter int N_DED = `PLD_DED_INPUTS,
  parameter int N_MC = `PLD_MACROCELLS,
  parameter int N_COLS = `PLD_COLS,
  parameter int N_TERMS = `PLD_TERMS_TOTAL,
  parameter int ADDR_W = `PLD_ADDR_W,
  parameter int SEL_W = `PLD_SEL_W
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [N_DED-1:0] ded_in,
  input wire logic [N_MC-1:0] io_in,
  output logic [N_MC-1:0] io_out,
  output logic [N_MC-1:0] io_oe_n,
  input wire logic [N_TERMS*N_COLS-1:0] array_fuse,
  input wire logic [N_MC-1:0] feedback_mode_fuse,
  input wire logic [N_MC-1:0] output_polarity_fuse,
  input wire logic security_fuse,
  input wire logic preload_en,
  input wire logic [SEL_W-1:0] preload_sel,
  input wire logic preload_val,
  input wire logic verify_en,
  input wire logic [ADDR_W-1:0] verify_addr,
  output logic verify_valid,
  output logic verify_data
);

  // Term count of each macrocell
  function automatic int term_count(input int mc);
    int n;
    n = 0;
    unique case (mc)
      0: n = `PLD_TERMS_MC0;
      1: n = `PLD_TERMS_MC1;
      2: n = `PLD_TERMS_MC2;
      3: n = `PLD_TERMS_MC3;
      4: n = `PLD_TERMS_MC4;
      5: n = `PLD_TERMS_MC5;
      6: n = `PLD_TERMS_MC6;
      7: n = `PLD_TERMS_MC7;
      8: n = `PLD_TERMS_MC8;
      9: n = `PLD_TERMS_MC9;
      default: n = 0;
    endcase
    return n;
  endfunction : term_count

  // First sum term of a macrocell
  function automatic int term_base(input int mc);
    int b;
    b = 0;
    for (int k = 0; k < mc; k++) begin
      b += term_count(k);
    end
    return b;
  endfunction : term_base

  logic [N_DED-1:0] ded_meta_ff;
  logic [N_DED-1:0] ded_sync_ff;
  logic [N_MC-1:0] pin_meta_ff;
  logic [N_MC-1:0] pin_sync_ff;
  pld_pkg::array_in_t array_in;
  pld_pkg::lit_vec_t lits;
  logic [N_TERMS-1:0] term_vec;
  pld_pkg::mc_vec_t feedback;
  pld_pkg::mc_vec_t pin_level;
  pld_pkg::mc_vec_t q_vis;
  pld_pkg::mc_vec_t oe_term;
  pld_pkg::mc_vec_t preload_hit;
  logic set_term;
  logic reset_term;
  logic [N_MC-1:0] io_out_ff;
  logic [N_MC-1:0] io_oe_n_ff;
  logic verify_valid_ff;
  logic verify_data_ff;
  logic nxt_verify_data;
  logic [`PLD_FUSE_TOTAL-1:0] all_fuses;

  // Two-stage sync of dedicated inputs
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ded_meta_ff <= '0;
      ded_sync_ff <= '0;
    end else begin
      ded_meta_ff <= ded_in;
      ded_sync_ff <= ded_meta_ff;
    end
  end

  // Two-stage sync of pin levels
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= io_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Array inputs: dedicated pins low, macrocell feedback high
  assign array_in = {feedback, ded_sync_ff};

  // True and complement column of every array input
  always_comb begin
    lits = '0;
    for (int k = 0; k < `PLD_ARRAY_INPUTS; k++) begin
      lits[2*k] = array_in[k];
      lits[2*k+1] = ~array_in[k];
    end
  end

  // AND plane: one term per fuse row
  for (genvar t = 0; t < N_TERMS; t++) begin : g_term
    sop_term #(
      .WIDTH(N_COLS)
    ) u_term (
      .lits(lits),
      .fuse_open(array_fuse[t*N_COLS +: N_COLS]),
      .term(term_vec[t])
    );
  end

  // Shared set and reset terms
  assign set_term = term_vec[`PLD_TERM_SET];
  assign reset_term = term_vec[`PLD_TERM_RESET];

  // Enable terms, one per pin
  assign oe_term = term_vec[`PLD_TERM_OE_BASE +: `PLD_MACROCELLS];

  // Macrocells with their own term slices
  for (genvar i = 0; i < N_MC; i++) begin : g_mc
    assign preload_hit[i] = preload_en && (preload_sel == SEL_W'(i));

    macrocell_slice #(
      .N_TERMS(term_count(i))
    ) u_mc (
      .core_clk(core_clk),
      .rstn(rstn),
      .terms(term_vec[term_base(i) +: term_count(i)]),
      .set_term(set_term),
      .reset_term(reset_term),
      .preload_load(preload_hit[i]),
      .preload_val(preload_val),
      .feedback_mode_fuse(feedback_mode_fuse[i]),
      .output_polarity_fuse(output_polarity_fuse[i]),
      .pin_in(pin_sync_ff[i]),
      .q_vis(q_vis[i]),
      .feedback(feedback[i]),
      .pin_level(pin_level[i])
    );
  end

  // Pin drivers; enable low drives, released while reset holds
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      io_out_ff <= '0;
      io_oe_n_ff <= '1;
    end else begin
      io_out_ff <= pin_level;
      io_oe_n_ff <= ~oe_term;
    end
  end

  assign io_out = io_out_ff;
  assign io_oe_n = io_oe_n_ff;

  // Flat fuse map for the read path
  assign all_fuses = {security_fuse, feedback_mode_fuse, output_polarity_fuse, array_fuse};

  // Fuse read; security blown makes every fuse look open
  always_comb begin
    nxt_verify_data = `PLD_FUSE_OPEN;
    if (!security_fuse && verify_addr < `PLD_FUSE_TOTAL) begin
      nxt_verify_data = all_fuses[verify_addr];
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      verify_valid_ff <= 1'h0;
      verify_data_ff <= 1'h0;
    end else begin
      verify_valid_ff <= verify_en;
      if (verify_en) begin
        verify_data_ff <= nxt_verify_data;
      end
    end
  end

  assign verify_valid = verify_valid_ff;
  assign verify_data = verify_data_ff;

  sequence s_read_req;
    verify_en && !security_fuse && (verify_addr < `PLD_FUSE_TOTAL);
  endsequence

  // Enable flop follows its term
  a_pin_enable: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) |-> io_oe_n_ff == ~$past(oe_term))
    else $error("pin enable does not follow its term");

  // Secured reads show open
  a_verify_secure: assert property (@(posedge core_clk) disable iff (!rstn)
    verify_en && security_fuse |=> verify_valid_ff && verify_data_ff)
    else $error("secured fuse read not open");

  // Intact fuse reads back intact
  a_verify_read: assert property (@(posedge core_clk) disable iff (!rstn)
    s_read_req ##0 (all_fuses[verify_addr] == 1'h0) |=> verify_valid_ff && !verify_data_ff)
    else $error("intact fuse misread");

  // Pin flop keeps the masked level
  a_pin_after_reset: assert property (@(posedge core_clk) disable iff (!rstn)
    $past(rstn) && $past(reset_term) |-> io_out_ff == $past(pin_level))
    else $error("pin level lost after reset term");

  // Set term with nothing above it
  sequence s_set_all;
    set_term && !reset_term && !preload_en;
  endsequence

  // No fuse read asked for
  sequence s_read_idle;
    !verify_en;
  endsequence

  // Set reaches every register
  a_set_all_regs: assert property (@(posedge core_clk) disable iff (!rstn)
    s_set_all ##1 !reset_term |-> q_vis == '1)
    else $error("set term missed a register");

  // Set level shows on registered pins through polarity
  a_set_pin_level: assert property (@(posedge core_clk) disable iff (!rstn)
    s_set_all ##1 !reset_term |=>
      ((io_out_ff ^ output_polarity_fuse) & ~feedback_mode_fuse) == '0)
    else $error("registered pin wrong after set");

  // Reset term masks every register at once
  a_reset_all_regs: assert property (@(posedge core_clk) disable iff (!rstn)
    reset_term |-> q_vis == '0)
    else $error("reset term left a register set");

  // Power-up level on registered pins follows polarity
  a_powerup_pins: assert property (@(posedge core_clk) disable iff (!rstn)
    rstn && !$past(rstn) |=>
      ((io_out_ff ^ output_polarity_fuse) | feedback_mode_fuse) == '1)
    else $error("power-up pin level wrong");

  // Combinational cells feed their synced pin back
  a_comb_feedback: assert property (@(posedge core_clk) disable iff (!rstn)
    ((feedback ^ pin_sync_ff) & feedback_mode_fuse) == '0)
    else $error("combinational feedback not from pin");

  // Registered cells feed their register back
  a_reg_feedback: assert property (@(posedge core_clk) disable iff (!rstn)
    !reset_term |-> ((feedback ^ q_vis) & ~feedback_mode_fuse) == '0)
    else $error("registered feedback not from register");

  // Both input groups pass exactly two flops
  a_sync_depth: assert property (@(posedge core_clk) disable iff (!rstn)
    {ded_sync_ff, pin_sync_ff} == $past({ded_meta_ff, pin_meta_ff}))
    else $error("input sync depth wrong");

  // Only the selected cell takes a preload
  a_preload_select: assert property (@(posedge core_clk) disable iff (!rstn)
    $onehot0(preload_hit) && (preload_en || preload_hit == '0))
    else $error("preload reached a wrong cell");

  // Reads past the map show an open fuse
  a_read_refused: assert property (@(posedge core_clk) disable iff (!rstn)
    verify_en && verify_addr >= `PLD_FUSE_TOTAL |=> verify_valid_ff && verify_data_ff)
    else $error("out of map read not open");

  // Valid only after a request
  a_verify_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
    s_read_idle |=> !verify_valid_ff)
    else $error("read answer without request");

  // Read data holds between requests
  a_verify_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    s_read_idle |=> $stable(verify_data_ff))
    else $error("read data changed without request");

endmodule : pld_output_macrocell_array

// File: bench/pin_partner.sv
// External logic at the ten two-way pins: resolves each wire for the array.
// Assumes the device drive wins while io_oe_n is low; no pull on any pin.
module pin_partner (
  input wire logic core_clk,
  input wire pld_pkg::mc_vec_t io_out,
  input wire pld_pkg::mc_vec_t io_oe_n,
  input wire pld_pkg::mc_vec_t ext_d,
  input wire pld_pkg::mc_vec_t ext_en,
  output pld_pkg::mc_vec_t io_in
);
  timeunit 1ns;
  timeprecision 1ps;
  pld_pkg::mc_vec_t churn_ff = 10'h155;

  // Undriven wire shows a pattern that moves every cycle
  always_ff @(posedge core_clk) begin
    churn_ff <= ~churn_ff;
  end

  // Device drive, else external drive, else floating pattern
  always_comb begin
    io_in = (~io_oe_n & io_out) | (io_oe_n & ext_en & ext_d)
      | (io_oe_n & ~ext_en & churn_ff);
  end
endmodule : pin_partner

// File: bench/tb.sv
// Self-checking bench of the array logic model with a fixed fuse map.
// Assumes pld_pkg, the design and pin_partner are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rstn, sec, pl_en, pl_val, v_en, v_valid, v_data;
  logic [11:0] ded_in;
  logic [3:0] pl_sel;
  logic [12:0] v_addr;
  logic [5807:0] fz;
  pld_pkg::mc_vec_t io_in, io_out, io_oe_n, mode, pol, ext_d, ext_en;
  int errors, total_checks, seed, d0, en, e;

  pld_output_macrocell_array i_dut (.core_clk(core_clk), .rstn(rstn), .ded_in(ded_in),
    .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .array_fuse(fz),
    .feedback_mode_fuse(mode), .output_polarity_fuse(pol), .security_fuse(sec),
    .preload_en(pl_en), .preload_sel(pl_sel), .preload_val(pl_val), .verify_en(v_en),
    .verify_addr(v_addr), .verify_valid(v_valid), .verify_data(v_data));

  pin_partner i_pins (.core_clk(core_clk), .io_out(io_out), .io_oe_n(io_oe_n),
    .ext_d(ext_d), .ext_en(ext_en), .io_in(io_in));

  // Clock at 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Pin level of a register value through its polarity
  function automatic logic pin_of(input logic q, input logic p);
    return p ? q : ~q;
  endfunction : pin_of

  task automatic chk(input logic [9:0] g, input logic [9:0] x);
    total_checks++;
    if (g !== x) begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, g, x);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic drv(input logic [11:0] d);
    @(posedge core_clk);
    ded_in <= d;
  endtask : drv

  // One fuse read: request one cycle, answer at the next edge
  task automatic rd(input logic [12:0] a, input logic x);
    @(posedge core_clk);
    v_en <= 1'b1;
    v_addr <= a;
    @(posedge core_clk);
    v_en <= 1'b0;
    #1;
    chk(10'(v_valid), 10'h001);
    chk(10'(v_data), 10'(x));
  endtask : rd

  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Watchdog
  initial begin
    #200000;
    errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    seed = 32'h5e93;
    {rstn, sec, pl_en, pl_val, v_en, pl_sel, v_addr, ded_in, ext_d} = '0;
    ext_en = 10'h3ff;
    mode = 10'h003; // Cells 0 and 1 combinational
    pol = pld_pkg::mc_vec_t'($random(seed));
    pol[1:0] = 2'b01;
    fz = '1;
    for (int t = 0; t < 120; t++) fz[t*44 +: 2] = 2'b00; // Contradiction: term false
    fz[1:0] = 2'b11;
    fz[26] = 1'b0; // Cell 0 sums pin of cell 1
    fz[8*44 +: 2] = 2'b10; // Cell 1 sums ded_in[0]
    fz[121*44+22] = 1'b0; // Cell 1 enable is ded_in[11]
    fz[130*44+20] = 1'b0; // Set term is ded_in[10]
    fz[131*44+18] = 1'b0; // Reset term is ded_in[9]
    tick(8);
    chk(io_oe_n, 10'h3ff); // Pins released in reset
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    tick(7);
    chk(io_out & 10'h3fc, ~pol & 10'h3fc);
    chk(io_oe_n, 10'h002);
    $display("power-up test done");
    // Random pin traffic through cells 1 and 0
    for (int k = 0; k < 12; k++) begin
      d0 = $random(seed);
      en = (k < 2) ? k : $random(seed);
      e = $random(seed);
      @(posedge core_clk);
      ext_d <= {8'h00, e[0], 1'b0};
      drv({en[0], 2'b00, 8'(d0 >> 1), d0[0]});
      tick(7);
      chk({9'h000, io_oe_n[1]}, {9'h000, ~en[0]});
      chk({9'h000, io_out[0]}, {9'h000, en[0] ? ~d0[0] : e[0]});
      if (en[0]) chk({9'h000, io_out[1]}, {9'h000, ~d0[0]});
    end
    $display("pin traffic test done");
    // Set term: register at third edge, pin at fourth
    drv(12'h400);
    tick(3);
    chk(io_out & 10'h3fc, ~pol & 10'h3fc);
    tick(1);
    chk(io_out & 10'h3fc, pol & 10'h3fc);
    drv(12'h600);
    tick(7);
    chk(io_out & 10'h3fc, ~pol & 10'h3fc);
    drv(12'h400);
    tick(7);
    drv(12'h200);
    tick(7);
    chk(io_out & 10'h3fc, ~pol & 10'h3fc);
    drv(12'h000);
    tick(3); // Let the reset term leave the sync flops before preloading
    $display("set and reset test done");
    // Preload each registered cell with a random value
    for (int c = 2; c < 10; c++) begin
      e = $random(seed);
      @(posedge core_clk);
      pl_en <= 1'b1;
      pl_sel <= 4'(c);
      pl_val <= e[0];
      @(posedge core_clk);
      pl_en <= 1'b0;
      tick(1);
      chk(10'(io_out[c]), 10'(pin_of(e[0], pol[c])));
      tick(1);
      chk(10'(io_out[c]), 10'(pin_of(1'b0, pol[c])));
    end
    $display("preload test done");
    // Fuse reads, then with security blown
    for (int c = 0; c < 10; c++) begin
      rd(13'(5808 + c), pol[c]);
      rd(13'(5818 + c), mode[c]);
    end
    rd(13'h001A, 1'b0);
    rd(13'h16C5, 1'b1);
    @(posedge core_clk);
    sec <= 1'b1;
    rd(13'h001A, 1'b1);
    rd(13'h16B1, 1'b1);
    $display("fuse read test done");
    complete_run();
  end
endmodule : tb
